// ==== chan_pkg.sv ====
package chan_pkg;

  // ----------------------------------------------------------------
  // Register word indexes (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [13:0] MODE_IDX = 14'h0884;
  localparam logic [13:0] EVENT_IDX = 14'h0888;
  localparam logic [13:0] MASK_IDX = 14'h088A;
  localparam logic [13:0] STATUS_IDX = 14'h088C;
  localparam logic [13:0] CONFIG_IDX = 14'h0980;
  localparam logic [13:0] PARAM_IDX = 14'h0900;
  localparam logic [13:0] DESC_IDX = 14'h0940;

  // ----------------------------------------------------------------
  // Memory shapes
  // ----------------------------------------------------------------
  localparam int PARAM_WORDS = 32;
  localparam int GENERAL_WORDS = 14;
  localparam int PROTO_WORDS = 18;
  localparam int DESC_WORDS = 64;
  localparam logic [4:0] PARAM_FC_WORD = 5'h00;
  localparam logic [4:0] PARAM_MRBL_WORD = 5'h01;
  localparam int RX_FC_LSB = 12;
  localparam int TX_FC_LSB = 4;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int MODE_ENR = 3;
  localparam int MODE_ENT = 2;
  localparam int CFG_MUX = 0;
  localparam int BD_READY = 15;
  localparam int BD_EXT = 14;
  localparam int BD_WRAP = 13;
  localparam int BD_INT = 12;
  localparam int BD_LAST = 11;
  localparam logic [15:0] RX_KEEP = 16'h7FC0;
  localparam logic [15:0] TX_KEEP = 16'h7FFC;
  localparam int EV_RX = 0;
  localparam int EV_TX = 1;
  localparam int EV_BSY = 2;
  localparam int EV_RCH = 3;
  localparam int EV_TXE = 4;
  localparam int EV_CD = 6;
  localparam int EV_CTS = 7;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [7:0] EV_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  // Sync order: grant, cts_n, cd_n, tclk, rclk, rxd
  localparam logic [5:0] SYNC_RST = 6'h19;

  typedef struct packed {
    logic [31:0] addr;
    logic [2:0] fc;
    logic ext;
  } buf_req_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SEND = 3'b010,
    TX_DONE = 3'b100
  } tx_state_t;

endpackage : chan_pkg

// ==== chan_buffer_logic.sv ====
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
module chan_buffer_logic (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [15:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_rxd,
  input wire logic i_rclk,
  input wire logic i_tclk,
  input wire logic i_cd_n,
  input wire logic i_cts_n,
  input wire logic i_grant,
  output logic o_txd,
  output logic o_tx_in_block,
  output logic o_event_req,
  output chan_pkg::buf_req_t o_wr_req,
  output logic [7:0] o_wr_data,
  output logic o_wr_valid,
  input wire logic i_wr_ready,
  output chan_pkg::buf_req_t o_rd_req,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  input wire logic [7:0] i_rd_data
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pin_raw;
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic [5:0] s3_q;
  assign pin_raw = {i_grant, i_cts_n, i_cd_n, i_tclk, i_rclk, i_rxd};

  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_sync
      always_ff @(posedge i_clk or negedge i_nrst)
      begin
        if (!i_nrst)
        begin
          s1_q[g] <= chan_pkg::SYNC_RST[g];
          s2_q[g] <= chan_pkg::SYNC_RST[g];
          s3_q[g] <= chan_pkg::SYNC_RST[g];
        end
        else
        begin
          s1_q[g] <= pin_raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
        end
      end
    end
  endgenerate

  logic rx_sample;
  logic tx_shift;
  logic cd_n_s;
  logic cts_n_s;
  assign rx_sample = s2_q[1] & ~s3_q[1];
  assign tx_shift = s3_q[2] & ~s2_q[2];
  assign cd_n_s = s2_q[3];
  assign cts_n_s = s2_q[4];

  // ----------------------------------------------------------------
  // Registers and memories
  // ----------------------------------------------------------------
  logic [15:0] mode_q;
  logic [7:0] ev_q;
  logic [7:0] ev_set;
  logic [7:0] mask_q;
  logic [7:0] line_status;
  logic cfg_mux_q;
  logic [15:0] param_q [0:chan_pkg::PARAM_WORDS-1];
  logic [15:0] desc_q [0:chan_pkg::DESC_WORDS-1];
  logic receiver_on_bit;
  logic transmitter_on_bit;
  assign receiver_on_bit = mode_q[chan_pkg::MODE_ENR];
  assign transmitter_on_bit = mode_q[chan_pkg::MODE_ENT];

  logic [13:0] idx;
  logic bus_req;
  logic bus_wr;
  logic param_hit;
  logic desc_hit;
  logic [15:0] wmask;
  logic [15:0] rd_word;
  logic ack_q;
  logic [31:0] rdat_q;
  assign idx = i_wb_adr[15:2];
  assign bus_req = i_wb_cyc & i_wb_stb;
  // Writes land on the acked edge, when the master samples ack
  assign bus_wr = bus_req & i_wb_we & ack_q;
  assign param_hit = idx[13:5] == chan_pkg::PARAM_IDX[13:5];
  assign desc_hit = idx[13:6] == chan_pkg::DESC_IDX[13:6];
  assign wmask = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [15:0] m);
    merge16 = (old_v & ~m) | (new_v & m);
  endfunction : merge16

  // Unmapped reads answer zero; writes there are dropped
  always_comb
  begin
    rd_word = 16'h0000;
    if (param_hit)
      rd_word = param_q[idx[4:0]];
    else if (desc_hit)
      rd_word = desc_q[idx[5:0]];
    else
    begin
      case (idx)
        chan_pkg::MODE_IDX: rd_word = mode_q;
        chan_pkg::EVENT_IDX: rd_word = {8'h00, ev_q};
        chan_pkg::MASK_IDX: rd_word = {8'h00, mask_q};
        chan_pkg::STATUS_IDX: rd_word = {8'h00, line_status};
        chan_pkg::CONFIG_IDX: rd_word = {15'h0000, cfg_mux_q};
        default: rd_word = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= bus_req & ~ack_q;
      if (bus_req & ~ack_q)
        rdat_q <= {16'h0000, rd_word};
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      mode_q <= chan_pkg::MODE_RST;
      mask_q <= chan_pkg::MASK_RST;
      cfg_mux_q <= 1'b0;
    end
    else if (bus_wr)
    begin
      if (idx == chan_pkg::MODE_IDX)
        mode_q <= merge16(mode_q, i_wb_dat[15:0], wmask);
      if (idx == chan_pkg::MASK_IDX && i_wb_sel[0])
        mask_q <= i_wb_dat[7:0];
      if (idx == chan_pkg::CONFIG_IDX && i_wb_sel[0])
        cfg_mux_q <= i_wb_dat[chan_pkg::CFG_MUX];
    end
  end

  // clear on ones
  // Set wins over a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      ev_q <= chan_pkg::EV_RST;
    else if (bus_wr && idx == chan_pkg::EVENT_IDX && i_wb_sel[0])
      ev_q <= (ev_q & ~i_wb_dat[7:0]) | ev_set;
    else
      ev_q <= ev_q | ev_set;
  end

  assign o_event_req = |(ev_q & mask_q);

  // ----------------------------------------------------------------
  // Line status
  // ----------------------------------------------------------------
  logic rclk_seen_q;
  logic tclk_seen_q;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rclk_seen_q <= 1'b0;
      tclk_seen_q <= 1'b0;
    end
    else
    begin
      rclk_seen_q <= receiver_on_bit & (rclk_seen_q | rx_sample);
      tclk_seen_q <= transmitter_on_bit & (tclk_seen_q | tx_shift);
    end
  end
  // level view
  // Outside its valid window a level reads as not asserted
  assign line_status = {(transmitter_on_bit & tclk_seen_q) ? cts_n_s : 1'b1,
                        (receiver_on_bit & rclk_seen_q) ? cd_n_s : 1'b1, 6'h00};

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  logic [2:0] rx_idx_q;
  logic [5:0] rx_base;
  logic [5:0] rx_lenw;
  logic [15:0] rx_ctrl;
  logic [15:0] mrbl;
  logic [7:0] rx_sh_q;
  logic [2:0] rx_bit_q;
  logic rx_half_q;
  logic [7:0] hold_q;
  logic hold_v_q;
  logic [15:0] rx_cnt_q;
  logic [15:0] rx_len_d;
  logic rx_run;
  logic byte_done;
  logic wr_fire;
  logic bsy_drop;
  logic rx_ov;
  logic cd_lost;
  logic rx_full;
  logic rx_close;
  logic rx_empty;
  assign rx_base = {1'b0, rx_idx_q, 2'b00};
  assign rx_lenw = {1'b0, rx_idx_q, 2'b01};
  assign rx_ctrl = desc_q[rx_base];
  assign mrbl = param_q[chan_pkg::PARAM_MRBL_WORD];
  assign rx_empty = rx_ctrl[chan_pkg::BD_READY];
  assign rx_run = receiver_on_bit & (cfg_mux_q | ~cd_n_s);
  assign byte_done = rx_sample & rx_run & (rx_bit_q == 3'h7);
  assign o_wr_valid = hold_v_q & rx_empty & receiver_on_bit;
  assign wr_fire = o_wr_valid & i_wr_ready;
  assign bsy_drop = hold_v_q & ~rx_empty & receiver_on_bit;
  assign rx_ov = byte_done & hold_v_q & ~(wr_fire | bsy_drop);
  assign cd_lost = ~cfg_mux_q & receiver_on_bit & s2_q[3] & ~s3_q[3] &
                   (rx_cnt_q != 16'h0000);
  assign rx_len_d = rx_cnt_q + {15'h0000, wr_fire};
  // length cap
  // Zero means no cap; a shrunk cap still closes the buffer
  assign rx_full = wr_fire & (mrbl != 16'h0000) & (rx_len_d >= mrbl);
  assign rx_close = receiver_on_bit & rx_empty & (rx_full | rx_ov | cd_lost);
  assign o_wr_data = hold_q;
  assign o_wr_req = '{addr: {desc_q[rx_base + 6'h02], desc_q[rx_base + 6'h03]}
                           + {16'h0000, rx_cnt_q},
                     fc: param_q[chan_pkg::PARAM_FC_WORD]
                           [chan_pkg::RX_FC_LSB +: 3],
                     ext: rx_ctrl[chan_pkg::BD_EXT]};

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rx_sh_q <= 8'h00;
      rx_bit_q <= 3'h0;
      rx_half_q <= 1'b0;
      hold_q <= 8'h00;
      hold_v_q <= 1'b0;
    end
    else
    begin
      if (!rx_run)
      begin
        rx_bit_q <= 3'h0;
        rx_half_q <= 1'b0;
      end
      else if (rx_sample)
      begin
        rx_sh_q <= {s2_q[0], rx_sh_q[7:1]};
        rx_bit_q <= rx_bit_q + 3'h1;
        if (byte_done)
          rx_half_q <= ~rx_half_q;
      end
      if (!receiver_on_bit)
        hold_v_q <= 1'b0;
      else if (byte_done && (!hold_v_q || wr_fire || bsy_drop))
      begin
        hold_q <= {s2_q[0], rx_sh_q[7:1]};
        hold_v_q <= 1'b1;
      end
      else if (wr_fire || bsy_drop)
        hold_v_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rx_idx_q <= 3'h0;
      rx_cnt_q <= 16'h0000;
    end
    else if (!receiver_on_bit)
    begin
      rx_idx_q <= 3'h0;
      rx_cnt_q <= 16'h0000;
    end
    else if (rx_close)
    begin
      rx_idx_q <= rx_ctrl[chan_pkg::BD_WRAP] ? 3'h0 : rx_idx_q + 3'h1;
      rx_cnt_q <= 16'h0000;
    end
    else if (wr_fire)
      rx_cnt_q <= rx_len_d;
  end

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  chan_pkg::tx_state_t tx_q;
  logic [2:0] tx_idx_q;
  logic [5:0] tx_base;
  logic [15:0] tx_ctrl;
  logic [15:0] tx_len;
  logic [15:0] fetch_q;
  logic [15:0] sent_q;
  logic [7:0] thold_q;
  logic thold_v_q;
  logic [7:0] tsh_q;
  logic [2:0] bits_q;
  logic rd_fire;
  logic perm_lost;
  logic last_bit;
  logic [1:0] tx_err;
  logic tx_close;
  assign tx_base = {1'b1, tx_idx_q, 2'b00};
  assign tx_ctrl = desc_q[tx_base];
  assign tx_len = desc_q[tx_base + 6'h01];
  assign o_rd_valid = (tx_q == chan_pkg::TX_SEND) & ~thold_v_q &
                      (fetch_q != tx_len);
  assign rd_fire = o_rd_valid & i_rd_ready;
  assign o_rd_req = '{addr: {desc_q[tx_base + 6'h02], desc_q[tx_base + 6'h03]}
                           + {16'h0000, fetch_q},
                     fc: param_q[chan_pkg::PARAM_FC_WORD]
                           [chan_pkg::TX_FC_LSB +: 3],
                     ext: tx_ctrl[chan_pkg::BD_EXT]};
  assign perm_lost = cfg_mux_q ? ~s2_q[5] : cts_n_s;
  assign last_bit = tx_shift & (bits_q == 3'h0);
  // Before the first byte the line is idle, not starved
  assign tx_err = {last_bit & (sent_q != tx_len) & (sent_q != 16'h0000) &
                   ~thold_v_q & ~perm_lost, perm_lost};
  assign tx_close = (tx_q == chan_pkg::TX_SEND) & transmitter_on_bit &
                    (perm_lost | (last_bit & (sent_q == tx_len)) |
                     tx_err[1]);

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      tx_q <= chan_pkg::TX_IDLE;
      tx_idx_q <= 3'h0;
      o_tx_in_block <= 1'b0;
    end
    else
    begin
      case (tx_q)
        chan_pkg::TX_IDLE:
        begin
          if (transmitter_on_bit && tx_ctrl[chan_pkg::BD_READY])
          begin
            tx_q <= chan_pkg::TX_SEND;
            o_tx_in_block <= 1'b1;
          end
        end
        chan_pkg::TX_SEND:
        begin
          if (!transmitter_on_bit)
            tx_q <= chan_pkg::TX_IDLE;
          else if (tx_close)
          begin
            tx_q <= chan_pkg::TX_DONE;
            tx_idx_q <= tx_ctrl[chan_pkg::BD_WRAP] ? 3'h0 :
                        tx_idx_q + 3'h1;
            if (tx_ctrl[chan_pkg::BD_LAST] || tx_err != 2'b00)
              o_tx_in_block <= 1'b0;
          end
        end
        // One idle cycle lets the closed word settle before re-polling
        chan_pkg::TX_DONE: tx_q <= chan_pkg::TX_IDLE;
        default: tx_q <= chan_pkg::TX_IDLE;
      endcase
      if (!transmitter_on_bit)
      begin
        tx_idx_q <= 3'h0;
        o_tx_in_block <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      fetch_q <= 16'h0000;
      sent_q <= 16'h0000;
      thold_q <= 8'h00;
      thold_v_q <= 1'b0;
      tsh_q <= 8'h00;
      bits_q <= 3'h0;
      o_txd <= 1'b1;
    end
    else if (tx_q != chan_pkg::TX_SEND || !transmitter_on_bit || tx_close)
    begin
      fetch_q <= 16'h0000;
      sent_q <= 16'h0000;
      thold_v_q <= 1'b0;
      bits_q <= 3'h0;
      o_txd <= 1'b1;
    end
    else
    begin
      if (rd_fire)
      begin
        thold_q <= i_rd_data;
        thold_v_q <= 1'b1;
        fetch_q <= fetch_q + 16'h0001;
      end
      if (tx_shift && bits_q != 3'h0)
      begin
        o_txd <= tsh_q[0];
        tsh_q <= {1'b1, tsh_q[7:1]};
        bits_q <= bits_q - 3'h1;
      end
      else if (last_bit && thold_v_q)
      begin
        o_txd <= thold_q[0];
        tsh_q <= {1'b1, thold_q[7:1]};
        bits_q <= 3'h7;
        sent_q <= sent_q + 16'h0001;
        thold_v_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Descriptor and parameter memories
  // ----------------------------------------------------------------
  // parameter words
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      for (int i = 0; i < chan_pkg::PARAM_WORDS; i++)
        param_q[i] <= 16'h0000;
    end
    else if (bus_wr && param_hit)
      param_q[idx[4:0]] <= merge16(param_q[idx[4:0]], i_wb_dat[15:0], wmask);
  end

  // descriptor rings
  // Hardware closes override a software write in the same cycle
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      for (int i = 0; i < chan_pkg::DESC_WORDS; i++)
        desc_q[i] <= 16'h0000;
    end
    else
    begin
      if (bus_wr && desc_hit)
        desc_q[idx[5:0]] <= merge16(desc_q[idx[5:0]], i_wb_dat[15:0], wmask);
      if (rx_close)
      begin
        desc_q[rx_base] <= (rx_ctrl & chan_pkg::RX_KEEP) |
                           {14'h0000, rx_ov, cd_lost};
        desc_q[rx_lenw] <= rx_len_d;
      end
      if (tx_close)
        desc_q[tx_base] <= (tx_ctrl & chan_pkg::TX_KEEP) | {14'h0000, tx_err};
    end
  end

  // ----------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------
  always_comb
  begin
    ev_set = 8'h00;
    ev_set[chan_pkg::EV_RX] = rx_close & rx_ctrl[chan_pkg::BD_INT];
    ev_set[chan_pkg::EV_TX] = tx_close & tx_ctrl[chan_pkg::BD_INT] &
                              (tx_err == 2'b00);
    ev_set[chan_pkg::EV_TXE] = tx_close & tx_ctrl[chan_pkg::BD_INT] &
                               (tx_err != 2'b00);
    ev_set[chan_pkg::EV_BSY] = bsy_drop;
    ev_set[chan_pkg::EV_RCH] = byte_done & rx_half_q;
    ev_set[chan_pkg::EV_CD] = s2_q[3] ^ s3_q[3];
    ev_set[chan_pkg::EV_CTS] = s2_q[4] ^ s3_q[4];
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_rx_close_int;
    rx_close && rx_ctrl[chan_pkg::BD_INT];
  endsequence
  sequence s_tx_close_err;
    tx_close && tx_ctrl[chan_pkg::BD_INT] && tx_err != 2'b00;
  endsequence

  a_rx_event_set: assert property (s_rx_close_int |=> ev_q[0])
    else $error("receive event missing after close");
  a_rx_event_quiet: assert property (rx_close && !rx_ctrl[12] && !ev_q[0]
                                     |=> !ev_q[0])
    else $error("receive event set without flag");
  a_irq_gate: assert property ((ev_q & mask_q) == 8'h00 |-> !o_event_req)
    else $error("request raised while masked");
  a_status_idle: assert property (!receiver_on_bit |-> line_status[6])
    else $error("carrier level shown while receiver off");
  a_rx_cap: assert property (mrbl != 16'h0000 && $stable(mrbl)
                             |-> rx_cnt_q < mrbl)
    else $error("receive count reached length cap");
  a_rx_close_word: assert property (rx_close |=> !desc_q[$past(rx_base)][15]
                                    && desc_q[$past(rx_lenw)]
                                       == $past(rx_len_d))
    else $error("receive close word wrong");
  a_store_empty: assert property (o_wr_valid |-> rx_empty && receiver_on_bit)
    else $error("store into non-empty descriptor");
  a_ring_wrap: assert property (rx_close && rx_ctrl[13] |=> rx_idx_q == 3'h0)
    else $error("ring did not wrap");
  a_tx_err_event: assert property (s_tx_close_err |=> ev_q[4])
    else $error("transmit error event missing");
  a_tx_ready_only: assert property (tx_q == chan_pkg::TX_IDLE ##1
                                    tx_q == chan_pkg::TX_SEND
                                    |-> $past(tx_ctrl[15]))
    else $error("transmit started on unready descriptor");
  a_tx_gate: assert property (!transmitter_on_bit |=> tx_q != chan_pkg::TX_SEND)
    else $error("transmitter ran while disabled");

endmodule : chan_buffer_logic

// ==== line_peer.sv ====
`timescale 1ns/1ps
module line_peer (
  input wire logic i_run,
  input wire logic [7:0] i_byte,
  output logic o_lclk,
  output logic o_data
);
  int k = 1;
  initial
  begin
    o_lclk = 1'b0;
    o_data = 1'b1;
  end
  // --------------------------------------------------------------
  // Line clock, low outside frames; first bit waits on the line
  // --------------------------------------------------------------
  always
  begin
    #80;
    if (i_run)
      o_lclk = ~o_lclk;
    else
    begin
      o_lclk = 1'b0;
      o_data = i_byte[0];
      k = 1;
    end
  end
  // Bits change on falling edge, LSB first
  always @(negedge o_lclk)
  begin
    if (i_run)
    begin
      o_data = i_byte[k];
      k = (k + 1) % 8;
    end
  end
endmodule : line_peer

// ==== chan_buffer_logic_tb.sv ====
`timescale 1ns/1ps
module chan_buffer_logic_tb;
  localparam logic [13:0] MD = chan_pkg::MODE_IDX;
  localparam logic [13:0] EV = chan_pkg::EVENT_IDX;
  localparam logic [13:0] MK = chan_pkg::MASK_IDX;
  localparam logic [13:0] PR = chan_pkg::PARAM_IDX;
  localparam logic [13:0] DB = chan_pkg::DESC_IDX;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, txd, in_blk, ev_req, wr_v, rd_v, rxd, rclk, tclk;
  logic cd_n = 1'b1;
  logic cts_n = 1'b1;
  logic rrun = 1'b0;
  logic trun = 1'b0;
  logic grant = 1'b0;
  logic [7:0] rdd = 8'hA5;
  logic [7:0] wr_b1 = 8'h00;
  logic [15:0] tx_sh = 16'h0000;
  logic [7:0] wr_d;
  chan_pkg::buf_req_t wr_rq, rd_rq, wr_1st, rd_1st;
  logic [15:0] v;
  int n_mismatch = 0;
  int cmp_count = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;

  always #4 clk = ~clk;

  chan_buffer_logic dut_u (
    .i_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(cyc),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'h3),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_rxd(rxd), .i_rclk(rclk),
    .i_tclk(tclk), .i_cd_n(cd_n), .i_cts_n(cts_n), .i_grant(grant),
    .o_txd(txd), .o_tx_in_block(in_blk), .o_event_req(ev_req),
    .o_wr_req(wr_rq), .o_wr_data(wr_d), .o_wr_valid(wr_v),
    .i_wr_ready(1'b1), .o_rd_req(rd_rq), .o_rd_valid(rd_v),
    .i_rd_ready(1'b1), .i_rd_data(rdd));
  line_peer rx_peer (.i_run(rrun), .i_byte(8'h3C), .o_lclk(rclk),
    .o_data(rxd));
  line_peer tx_peer (.i_run(trun), .i_byte(8'h00), .o_lclk(tclk),
    .o_data());

  // --------------------------------------------------------------
  // Buffer traffic counters, ready tied high so valid means taken
  // --------------------------------------------------------------
  always @(posedge clk)
  begin
    if (wr_v === 1'b1)
    begin
      if (wr_cnt == 0)
      begin
        wr_1st = wr_rq;
        wr_b1 = wr_d;
      end
      wr_cnt++;
    end
    if (rd_v === 1'b1)
    begin
      if (rd_cnt == 0)
        rd_1st = rd_rq;
      rdd <= 8'h5A;
      rd_cnt++;
    end
  end

  // Line bits seen by the peer while a block is open, LSB first
  always @(posedge tclk)
  begin
    if (in_blk === 1'b1)
      tx_sh = {txd, tx_sh[15:1]};
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic hang();
    n_mismatch++;
    $display("[ERR] %0t wait ran out", $time);
    end_of_test();
  endtask : hang

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Hold request until ack is sampled, then one idle cycle
  task automatic bus(input logic w, input logic [13:0] i,
                     input logic [15:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {16'h0000, d};
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    v = rdat[15:0];
    if (n >= 50)
      hang();
    cyc <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic rc(input logic [13:0] i, input logic [15:0] m,
                    input logic [15:0] e);
    bus(1'b0, i, 16'h0000);
    chk(36'(v & m), 36'(e));
  endtask : rc

  // Poll a control word until the device hands it back
  task automatic poll(input logic [13:0] i);
    int n;
    n = 0;
    do
    begin
      bus(1'b0, i, 16'h0000);
      n++;
    end while (v[15] !== 1'b0 && n < 1000);
    if (n >= 1000)
      hang();
  endtask : poll

  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rc(MD, 16'hFFFF, 16'h0000);
    rc(EV, 16'h00FF, 16'h0000);
    rc(MK, 16'h00FF, 16'h0000);
    rc(chan_pkg::STATUS_IDX, 16'h00C0, 16'h00C0);
    rc(14'h0004, 16'hFFFF, 16'h0000);
    $display("test reset done");
    cd_n <= 1'b0;
    cts_n <= 1'b0;
    bus(1'b1, EV, 16'h00FF);
    bus(1'b1, MK, 16'h0002);
    rc(MK, 16'h00FF, 16'h0002);
    bus(1'b1, PR, 16'h6050);
    bus(1'b1, PR + 14'h0001, 16'h0002);
    bus(1'b1, DB + 14'h0021, 16'h0002);
    bus(1'b1, DB + 14'h0023, 16'h1000);
    bus(1'b1, DB + 14'h0020, 16'hB800);
    trun <= 1'b1;
    bus(1'b1, MD, 16'h0004);
    poll(DB + 14'h0020);
    chk(36'(v), 36'h3800);
    repeat (200) @(posedge clk);
    chk(36'(rd_cnt), 36'h2);
    chk(rd_1st, {32'h1000, 3'h5, 1'b0});
    chk(36'(in_blk), 36'h0);
    chk(36'(tx_sh), 36'h5AA5);
    rc(EV, 16'h0013, 16'h0002);
    chk(36'(ev_req), 36'h1);
    bus(1'b1, MK, 16'h0000);
    chk(36'(ev_req), 36'h0);
    bus(1'b1, EV, 16'h0002);
    rc(EV, 16'h0002, 16'h0000);
    trun <= 1'b0;
    $display("test transmit done");
    bus(1'b1, MD, 16'h0000);
    bus(1'b1, DB + 14'h0003, 16'h2000);
    bus(1'b1, DB, 16'hB000);
    bus(1'b1, MD, 16'h0008);
    rrun <= 1'b1;
    poll(DB);
    chk(36'(v), 36'h3000);
    rc(DB + 14'h0001, 16'hFFFF, 16'h0002);
    rc(EV, 16'h0001, 16'h0001);
    chk(wr_1st, {32'h2000, 3'h6, 1'b0});
    chk(36'(wr_b1), 36'h3C);
    repeat (300) @(posedge clk);
    chk(36'(wr_cnt), 36'h2);
    rrun <= 1'b0;
    $display("test receive done");
    end_of_test();
  end
endmodule : chan_buffer_logic_tb
